// File: tmr_consts.svh
// Purpose: constants of the 16-bit timer control block
// Assumes: byte-wide register port, 8-bit addresses
// Notes: definitions only
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define TMR_ADDR_MAIN 8'h00
`define TMR_ADDR_WAVE 8'h01
`define TMR_ADDR_LEVEL 8'h02
`define TMR_ADDR_SPLIT 8'h03
`define TMR_ADDR_E_CLR 8'h04
`define TMR_ADDR_E_SET 8'h05
`define TMR_ADDR_F_CLR 8'h06
`define TMR_ADDR_F_SET 8'h07
`define TMR_ADDR_CNT 8'h20
`define TMR_ADDR_PER 8'h26
`define TMR_ADDR_CMP 8'h28
`define TMR_ADDR_PERBUF 8'h36
`define TMR_ADDR_CMPBUF 8'h38
`define TMR_ADDR_STEP 8'h02

// ****************************************************************
// field positions
// ****************************************************************
`define TMR_EN_BIT 0
`define TMR_PRESC_LSB 1
`define TMR_PRESC_MSB 3
`define TMR_MODE_LSB 0
`define TMR_MODE_MSB 2
`define TMR_ALOCK_BIT 3
`define TMR_CMPEN_LSB 4
`define TMR_CMPEN_MSB 6
`define TMR_LEVEL_MSB 2
`define TMR_SPLIT_BIT 0
`define TMR_DIR_BIT 0
`define TMR_UPDATE_LOCK_BIT 1
`define TMR_CMD_LSB 2
`define TMR_CMD_MSB 3
`define TMR_BV_MSB 3

// ****************************************************************
// codes
// ****************************************************************
`define TMR_CMD_NONE 2'h0
`define TMR_CMD_UPDATE 2'h1
`define TMR_CMD_RESTART 2'h2
`define TMR_CMD_HARDRST 2'h3
`define TMR_MODE_NORMAL 3'h0
`define TMR_MODE_FRQ 3'h1
`define TMR_MODE_ONE_RAMP 3'h3
`define TMR_MODE_PEAK 3'h5
`define TMR_MODE_BOTH 3'h6
`define TMR_MODE_FLOOR 3'h7

// ****************************************************************
// prescaler masks, divide by mask plus one
// ****************************************************************
`define TMR_DIV1 10'h000
`define TMR_DIV2 10'h001
`define TMR_DIV4 10'h003
`define TMR_DIV8 10'h007
`define TMR_DIV16 10'h00F
`define TMR_DIV64 10'h03F
`define TMR_DIV256 10'h0FF
`define TMR_DIV1024 10'h3FF

// ****************************************************************
// reset values
// ****************************************************************
`define TMR_RST_BYTE 8'h00
`define TMR_RST_CNT 16'h0000
`define TMR_RST_PER 16'hFFFF
`define TMR_RST_CMP 16'h0000
`define TMR_CNT_ONE 16'h0001
`define TMR_PS_ONE 10'h001

`endif

// File: tmr_pkg.sv
// Purpose: types of the 16-bit timer control block
// Assumes: nothing
// Notes: all state lives in one packed struct
`default_nettype none

package tmr_pkg;

  // ****************************************************************
  // block state
  // ****************************************************************
  typedef struct packed {
    logic enable;
    logic [2:0] prescSel;
    logic [2:0] cmpEn;
    logic autoLock;
    logic [2:0] mode;
    logic [2:0] wgOut;
    logic split;
    logic update_lock;
    logic dir;
    logic [3:0] bv;
    logic [15:0] cnt;
    logic [15:0] period_value;
    logic [15:0] perBuf;
    logic [2:0][15:0] cmp;
    logic [2:0][15:0] cmpBuf;
    logic [9:0] psCnt;
    logic [7:0] rdData;
    logic [2:0] pinOut;
    logic [2:0] pinOe;
  } tmr_state_t;

endpackage : tmr_pkg

`default_nettype wire

// File: tmr_normal_ctrl.sv
// Purpose: control registers and core of a 16-bit timer, normal mode
// Assumes: core_clk 125 MHz, byte register port, read data one cycle late
// Notes: split mode only raises dualEightBitSelect
//
// How it works
// - prescaler code 0..7 divides clock by 1,2,4,8,16,64,256,1024
// - main enable bit turns the timer on, clear keeps it off
// - compare enables override pin only in frequency or PWM modes
// - auto-lock holds lock set until all enabled compare buffers valid
// - lock then stays clear until next update, which loads and relocks
// - without auto-lock hardware never touches the lock bit
// - modes 000 normal, 001 frequency, 011 single-ramp PWM
// - modes 101,110,111 two-ramp PWM, update at bottom; 010,100 reserved
// - normal mode drives no waveform; others only with compare enable
// - level bits read and write waveform levels while disabled
// - split bit selects the dual eight-bit arrangement
// - ones written to clear-side control E clear those bits
// - control E reads the same through set and clear addresses
// - command: none, update, restart, hard reset unless enabled
// - command field always reads zero
// - lock clear loads buffers at update; lock set blocks loading
// - direction bit: 0 up, 1 down; hardware and software change it
// - buffer high-byte writes set valid flags; an unlocked update clears them
// - ones written to set-side control E set those bits
//
// The implementer's own choice: the strobed register port.
`default_nettype none
`include "tmr_consts.svh"

module tmr_normal_ctrl (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  output logic [7:0] regRdData,
  output logic [2:0] waveformOutputPin,
  output logic [2:0] waveformOverride,
  output logic dualEightBitSelect,
  output logic timerRunning
);

  // ****************************************************************
  // functions
  // ****************************************************************
  function automatic logic [9:0] divMask(input logic [2:0] code);
    logic [9:0] m;
    m = `TMR_DIV1;
    case (code)
      3'h1: m = `TMR_DIV2;
      3'h2: m = `TMR_DIV4;
      3'h3: m = `TMR_DIV8;
      3'h4: m = `TMR_DIV16;
      3'h5: m = `TMR_DIV64;
      3'h6: m = `TMR_DIV256;
      3'h7: m = `TMR_DIV1024;
      default: m = `TMR_DIV1;
    endcase
    return m;
  endfunction : divMask

  function automatic logic isTwoRamp(input logic [2:0] md);
    return (md == `TMR_MODE_PEAK) || (md == `TMR_MODE_BOTH) ||
      (md == `TMR_MODE_FLOOR);
  endfunction : isTwoRamp

  function automatic logic isWaveMode(input logic [2:0] md);
    return (md == `TMR_MODE_FRQ) || (md == `TMR_MODE_ONE_RAMP) ||
      isTwoRamp(md);
  endfunction : isWaveMode

  function automatic tmr_pkg::tmr_state_t resetState();
    tmr_pkg::tmr_state_t r;
    r = '0;
    r.cnt = `TMR_RST_CNT;
    r.period_value = `TMR_RST_PER;
    r.perBuf = `TMR_RST_PER;
    r.cmp = {3{`TMR_RST_CMP}};
    r.cmpBuf = {3{`TMR_RST_CMP}};
    return r;
  endfunction : resetState

  // ****************************************************************
  // state
  // ****************************************************************
  tmr_pkg::tmr_state_t state_reg;
  tmr_pkg::tmr_state_t state_next;
  logic tick;
  logic updCond;
  logic doUpdate;
  logic wrSet;
  logic [1:0] cmdCode;
  logic [3:0] bvSet;
  logic [15:0] topVal;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    state_next.rdData = `TMR_RST_BYTE;
    updCond = 1'b0;
    bvSet = 4'h0;
    wrSet = regWrStrobe && (regAddr == `TMR_ADDR_E_SET);
    cmdCode = wrSet ? regWrData[`TMR_CMD_MSB:`TMR_CMD_LSB] : `TMR_CMD_NONE;
    topVal = (state_reg.mode == `TMR_MODE_FRQ) ?
      state_reg.cmp[0] : state_reg.period_value;

    // prescaler: free count, tick when masked bits all ones
    state_next.psCnt = state_reg.enable ?
      state_reg.psCnt + `TMR_PS_ONE : 10'h000;
    tick = state_reg.enable && ((state_reg.psCnt &
      divMask(state_reg.prescSel)) == divMask(state_reg.prescSel));

    // counting sequence per mode
    if (tick) begin
      if (isTwoRamp(state_reg.mode)) begin
        if (!state_reg.dir) begin
          if (state_reg.cnt >= topVal) begin
            state_next.dir = 1'b1;
            state_next.cnt = state_reg.cnt - `TMR_CNT_ONE;
          end else begin
            state_next.cnt = state_reg.cnt + `TMR_CNT_ONE;
          end
        end else if (state_reg.cnt == `TMR_RST_CNT) begin
          state_next.dir = 1'b0;
          state_next.cnt = `TMR_CNT_ONE;
          updCond = 1'b1;
        end else begin
          state_next.cnt = state_reg.cnt - `TMR_CNT_ONE;
        end
      end else if (!state_reg.dir) begin
        if (state_reg.cnt >= topVal) begin
          // top and bottom meet on the wrap in one-ramp modes
          state_next.cnt = `TMR_RST_CNT;
          updCond = 1'b1;
        end else begin
          state_next.cnt = state_reg.cnt + `TMR_CNT_ONE;
        end
      end else if (state_reg.cnt == `TMR_RST_CNT) begin
        state_next.cnt = topVal;
        updCond = 1'b1;
      end else begin
        state_next.cnt = state_reg.cnt - `TMR_CNT_ONE;
      end
    end

    // update: load buffers unless locked
    doUpdate = updCond || (cmdCode == `TMR_CMD_UPDATE);
    if (doUpdate && !state_reg.update_lock) begin
      if (state_reg.bv[0]) begin
        state_next.period_value = state_reg.perBuf;
      end
      for (int i = 0; i < 3; i++) begin
        if (state_reg.bv[i + 1]) begin
          state_next.cmp[i] = state_reg.cmpBuf[i];
        end
      end
      // flags kept while locked, else auto-lock could never gather them
      state_next.bv = 4'h0;
      if (state_reg.autoLock) begin
        state_next.update_lock = 1'b1;
      end
    end else if (state_reg.autoLock) begin
      state_next.update_lock = (state_reg.bv[3:1] & state_reg.cmpEn) !=
        state_reg.cmpEn;
    end

    // register writes
    if (regWrStrobe) begin
      if (regAddr == `TMR_ADDR_MAIN) begin
        state_next.enable = regWrData[`TMR_EN_BIT];
        state_next.prescSel =
          regWrData[`TMR_PRESC_MSB:`TMR_PRESC_LSB];
      end else if (regAddr == `TMR_ADDR_WAVE) begin
        state_next.cmpEn = regWrData[`TMR_CMPEN_MSB:`TMR_CMPEN_LSB];
        state_next.autoLock = regWrData[`TMR_ALOCK_BIT];
        state_next.mode = regWrData[`TMR_MODE_MSB:`TMR_MODE_LSB];
      end else if (regAddr == `TMR_ADDR_LEVEL) begin
        // running generator owns the levels
        if (!state_reg.enable) begin
          state_next.wgOut = regWrData[`TMR_LEVEL_MSB:0];
        end
      end else if (regAddr == `TMR_ADDR_SPLIT) begin
        state_next.split = regWrData[`TMR_SPLIT_BIT];
      end else if (regAddr == `TMR_ADDR_E_CLR) begin
        if (regWrData[`TMR_UPDATE_LOCK_BIT]) begin
          state_next.update_lock = 1'b0;
        end
        if (regWrData[`TMR_DIR_BIT]) begin
          state_next.dir = 1'b0;
        end
      end else if (regAddr == `TMR_ADDR_E_SET) begin
        if (regWrData[`TMR_UPDATE_LOCK_BIT]) begin
          state_next.update_lock = 1'b1;
        end
        if (regWrData[`TMR_DIR_BIT]) begin
          state_next.dir = 1'b1;
        end
      end else if (regAddr == `TMR_ADDR_F_CLR) begin
        state_next.bv = state_next.bv & ~regWrData[`TMR_BV_MSB:0];
      end else if (regAddr == `TMR_ADDR_F_SET) begin
        state_next.bv = state_next.bv | regWrData[`TMR_BV_MSB:0];
      end else if (regAddr == `TMR_ADDR_CNT) begin
        state_next.cnt[7:0] = regWrData;
      end else if (regAddr == `TMR_ADDR_CNT + 8'h01) begin
        state_next.cnt[15:8] = regWrData;
      end else if (regAddr == `TMR_ADDR_PER) begin
        state_next.period_value[7:0] = regWrData;
      end else if (regAddr == `TMR_ADDR_PER + 8'h01) begin
        state_next.period_value[15:8] = regWrData;
      end else if (regAddr == `TMR_ADDR_PERBUF) begin
        state_next.perBuf[7:0] = regWrData;
      end else if (regAddr == `TMR_ADDR_PERBUF + 8'h01) begin
        state_next.perBuf[15:8] = regWrData;
        bvSet[0] = 1'b1;
      end
      for (int i = 0; i < 3; i++) begin
        if (regAddr == `TMR_ADDR_CMP + 8'(i * 2)) begin
          state_next.cmp[i][7:0] = regWrData;
        end else if (regAddr == `TMR_ADDR_CMP + 8'(i * 2 + 1)) begin
          state_next.cmp[i][15:8] = regWrData;
        end else if (regAddr == `TMR_ADDR_CMPBUF + 8'(i * 2)) begin
          state_next.cmpBuf[i][7:0] = regWrData;
        end else if (regAddr == `TMR_ADDR_CMPBUF + 8'(i * 2 + 1)) begin
          state_next.cmpBuf[i][15:8] = regWrData;
          bvSet[i + 1] = 1'b1;
        end
      end
    end
    // buffer write beats any clear in the same cycle
    state_next.bv = state_next.bv | bvSet;

    // waveform generator
    if (state_reg.enable) begin
      if (state_reg.mode == `TMR_MODE_FRQ) begin
        if (updCond) begin
          state_next.wgOut[0] = ~state_reg.wgOut[0];
        end
      end else if ((state_reg.mode == `TMR_MODE_ONE_RAMP) ||
          isTwoRamp(state_reg.mode)) begin
        for (int i = 0; i < 3; i++) begin
          state_next.wgOut[i] = state_next.cnt < state_next.cmp[i];
        end
      end
    end

    // commands
    if (cmdCode == `TMR_CMD_RESTART) begin
      state_next.cnt = `TMR_RST_CNT;
      state_next.dir = 1'b0;
      state_next.wgOut = 3'h0;
      state_next.psCnt = 10'h000;
    end else if ((cmdCode == `TMR_CMD_HARDRST) && !state_reg.enable) begin
      state_next = resetState();
    end

    // pins follow the next levels so they match the registers
    for (int i = 0; i < 3; i++) begin
      state_next.pinOe[i] = state_next.cmpEn[i] &&
        isWaveMode(state_next.mode);
    end
    state_next.pinOut = state_next.wgOut;

    // read data, one cycle after the strobe
    if (regRdStrobe) begin
      if (regAddr == `TMR_ADDR_MAIN) begin
        state_next.rdData = {4'h0, state_reg.prescSel, state_reg.enable};
      end else if (regAddr == `TMR_ADDR_WAVE) begin
        state_next.rdData = {1'b0, state_reg.cmpEn, state_reg.autoLock,
          state_reg.mode};
      end else if (regAddr == `TMR_ADDR_LEVEL) begin
        state_next.rdData = {5'h00, state_reg.wgOut};
      end else if (regAddr == `TMR_ADDR_SPLIT) begin
        state_next.rdData = {7'h00, state_reg.split};
      end else if ((regAddr == `TMR_ADDR_E_CLR) ||
          (regAddr == `TMR_ADDR_E_SET)) begin
        state_next.rdData = {4'h0, `TMR_CMD_NONE, state_reg.update_lock,
          state_reg.dir};
      end else if ((regAddr == `TMR_ADDR_F_CLR) ||
          (regAddr == `TMR_ADDR_F_SET)) begin
        state_next.rdData = {4'h0, state_reg.bv};
      end else if (regAddr == `TMR_ADDR_CNT) begin
        state_next.rdData = state_reg.cnt[7:0];
      end else if (regAddr == `TMR_ADDR_CNT + 8'h01) begin
        state_next.rdData = state_reg.cnt[15:8];
      end else if (regAddr == `TMR_ADDR_PER) begin
        state_next.rdData = state_reg.period_value[7:0];
      end else if (regAddr == `TMR_ADDR_PER + 8'h01) begin
        state_next.rdData = state_reg.period_value[15:8];
      end else if (regAddr == `TMR_ADDR_PERBUF) begin
        state_next.rdData = state_reg.perBuf[7:0];
      end else if (regAddr == `TMR_ADDR_PERBUF + 8'h01) begin
        state_next.rdData = state_reg.perBuf[15:8];
      end
      for (int i = 0; i < 3; i++) begin
        if (regAddr == `TMR_ADDR_CMP + 8'(i * 2)) begin
          state_next.rdData = state_reg.cmp[i][7:0];
        end else if (regAddr == `TMR_ADDR_CMP + 8'(i * 2 + 1)) begin
          state_next.rdData = state_reg.cmp[i][15:8];
        end else if (regAddr == `TMR_ADDR_CMPBUF + 8'(i * 2)) begin
          state_next.rdData = state_reg.cmpBuf[i][7:0];
        end else if (regAddr == `TMR_ADDR_CMPBUF + 8'(i * 2 + 1)) begin
          state_next.rdData = state_reg.cmpBuf[i][15:8];
        end
      end
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= resetState();
    end else begin
      state_reg <= state_next;
    end
  end

  assign regRdData = state_reg.rdData;
  assign waveformOutputPin = state_reg.pinOut;
  assign waveformOverride = state_reg.pinOe;
  assign dualEightBitSelect = state_reg.split;
  assign timerRunning = state_reg.enable;

  // ****************************************************************
  // checks
  // ****************************************************************
  AST_CMD_READS_ZERO: assert property (@(posedge core_clk) disable iff (rst)
    regRdStrobe && ((regAddr == `TMR_ADDR_E_CLR) ||
    (regAddr == `TMR_ADDR_E_SET)) |=> regRdData[3:2] == 2'h0)
    else $error("command field read back nonzero");

  AST_E_READ_STATUS: assert property (@(posedge core_clk) disable iff (rst)
    regRdStrobe && (regAddr == `TMR_ADDR_E_CLR) |=>
    regRdData[1:0] == $past({state_reg.update_lock, state_reg.dir}))
    else $error("control E read differs from status");

  AST_LOCK_UNTOUCHED: assert property (@(posedge core_clk) disable iff (rst)
    !state_reg.autoLock && !(regWrStrobe && ((regAddr == `TMR_ADDR_E_CLR)
    || (regAddr == `TMR_ADDR_E_SET))) |=> $stable(state_reg.update_lock))
    else $error("lock bit changed by hardware");

  AST_LOCK_BLOCKS: assert property (@(posedge core_clk) disable iff (rst)
    doUpdate && state_reg.update_lock && !(regWrStrobe &&
    (regAddr >= `TMR_ADDR_PER)) |=>
    $stable(state_reg.period_value) && $stable(state_reg.cmp))
    else $error("buffer loaded while locked");

  AST_BV_CLEARED: assert property (@(posedge core_clk) disable iff (rst)
    doUpdate && !state_reg.update_lock && !regWrStrobe |=>
    state_reg.bv == 4'h0)
    else $error("valid flags survived update");

  AST_AUTOLOCK_RELEASE: assert property (@(posedge core_clk)
    disable iff (rst) state_reg.autoLock && state_reg.update_lock && !doUpdate &&
    !regWrStrobe && ((state_reg.bv[3:1] & state_reg.cmpEn) ==
    state_reg.cmpEn) |=> !state_reg.update_lock)
    else $error("auto-lock did not release");

  AST_NO_WAVE_NORMAL: assert property (@(posedge core_clk) disable iff (rst)
    state_reg.mode == `TMR_MODE_NORMAL |->
    waveformOverride == 3'h0)
    else $error("override asserted in normal mode");

  AST_LEVEL_WRITE: assert property (@(posedge core_clk) disable iff (rst)
    regWrStrobe && (regAddr == `TMR_ADDR_LEVEL) && !state_reg.enable |=>
    waveformOutputPin == $past(regWrData[2:0]))
    else $error("level write not seen on waveform");

  AST_HARD_RESET: assert property (@(posedge core_clk) disable iff (rst)
    wrSet && (regWrData[3:2] == `TMR_CMD_HARDRST) && !state_reg.enable |=>
    state_reg.cnt == `TMR_RST_CNT && state_reg.mode == 3'h0 &&
    state_reg.bv == 4'h0)
    else $error("hard reset incomplete");

  AST_HARD_RESET_IGNORED: assert property (@(posedge core_clk)
    disable iff (rst) wrSet && (regWrData[3:2] == `TMR_CMD_HARDRST) &&
    state_reg.enable |=> timerRunning)
    else $error("hard reset acted while enabled");

  AST_RESTART: assert property (@(posedge core_clk) disable iff (rst)
    wrSet && (regWrData[3:2] == `TMR_CMD_RESTART) |=>
    state_reg.cnt == 16'h0000 && !state_reg.dir)
    else $error("restart did not clear counter");

  AST_TICK_RATE: assert property (@(posedge core_clk) disable iff (rst)
    tick && (state_reg.prescSel == 3'h7) |->
    state_reg.psCnt == 10'h3FF)
    else $error("divide by 1024 tick misplaced");

endmodule : tmr_normal_ctrl

`default_nettype wire

// File: tmr_normal_ctrl_tb.sv
// Purpose: self-checking bench of the timer control block
// Assumes: byte register port, read data one cycle after the strobe
// Notes: each scenario is one task; all waits are fixed or bounded
`default_nettype none

module tmr_normal_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk;
  logic rst;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic regWrStrobe;
  logic regRdStrobe;
  logic [7:0] regRdData;
  logic [2:0] waveformOutputPin;
  logic [2:0] waveformOverride;
  logic dualEightBitSelect;
  logic timerRunning;
  int fails;
  int compares;
  int divs [8] = '{1, 2, 4, 8, 16, 64, 256, 1024};

  tmr_normal_ctrl dut (
    .core_clk(core_clk),
    .rst(rst),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrStrobe(regWrStrobe),
    .regRdStrobe(regRdStrobe),
    .regRdData(regRdData),
    .waveformOutputPin(waveformOutputPin),
    .waveformOverride(waveformOverride),
    .dualEightBitSelect(dualEightBitSelect),
    .timerRunning(timerRunning)
  );

  // ****************************************************************
  // bus and compare tasks
  // ****************************************************************
  task automatic final_report();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // gap of one cycle between writes keeps each strobe edge unique
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStrobe <= 1'b1;
    @(posedge core_clk);
    regWrStrobe <= 1'b0;
  endtask : wr

  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    regAddr <= a;
    regRdStrobe <= 1'b1;
    @(posedge core_clk);
    regRdStrobe <= 1'b0;
    #1;
    chk(regRdData, exp);
  endtask : rdChk

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic tReset();
    for (int a = 0; a < 8; a++) begin
      rdChk(8'(a), 8'h00);
    end
    wr(8'h10, 8'hFF);
    rdChk(8'h10, 8'h00);
  endtask : tReset

  task automatic tCtrlE();
    wr(8'h05, 8'h03);
    rdChk(8'h04, 8'h03);
    rdChk(8'h05, 8'h03);
    wr(8'h04, 8'h01);
    rdChk(8'h05, 8'h02);
    wr(8'h04, 8'h02);
    rdChk(8'h04, 8'h00);
  endtask : tCtrlE

  task automatic tLevels();
    logic [7:0] modeMask;
    modeMask = 8'hEA;
    wr(8'h02, 8'h05);
    #1 chk({5'h00, waveformOutputPin}, 8'h05);
    rdChk(8'h02, 8'h05);
    // reserved and normal modes must never take the pin
    for (int m = 0; m < 8; m++) begin
      wr(8'h01, 8'h50 | 8'(m));
      #1 chk(8'(waveformOverride), modeMask[m] ? 8'h05 : 8'h00);
    end
    wr(8'h01, 8'h00);
    wr(8'h03, 8'h01);
    #1 chk({7'h00, dualEightBitSelect}, 8'h01);
    wr(8'h03, 8'h00);
    wr(8'h02, 8'h00);
  endtask : tLevels

  task automatic tPresc();
    for (int c = 0; c < 8; c++) begin
      wr(8'h05, 8'h0C);
      wr(8'h00, 8'((c << 1) | 1));
      #1 chk({7'h00, timerRunning}, 8'h01);
      repeat (8 * divs[c] - 2) @(posedge core_clk);
      wr(8'h00, 8'(c << 1));
      rdChk(8'h20, 8'h08);
    end
  endtask : tPresc

  task automatic tCmds();
    wr(8'h05, 8'h01);
    wr(8'h05, 8'h08);
    rdChk(8'h20, 8'h00);
    rdChk(8'h04, 8'h00);
    rdChk(8'h00, 8'h0E);
    wr(8'h00, 8'h0F);
    wr(8'h05, 8'h0C);
    rdChk(8'h00, 8'h0F);
    wr(8'h00, 8'h0E);
    wr(8'h05, 8'h0C);
    rdChk(8'h00, 8'h00);
  endtask : tCmds

  task automatic tBuffers();
    wr(8'h38, 8'h34);
    wr(8'h39, 8'h12);
    rdChk(8'h06, 8'h02);
    wr(8'h05, 8'h02);
    wr(8'h05, 8'h04);
    rdChk(8'h28, 8'h00);
    rdChk(8'h05, 8'h02);
    wr(8'h04, 8'h02);
    wr(8'h05, 8'h04);
    rdChk(8'h28, 8'h34);
    rdChk(8'h29, 8'h12);
    rdChk(8'h06, 8'h00);
    wr(8'h01, 8'h18);
    rdChk(8'h04, 8'h02);
    wr(8'h38, 8'h78);
    wr(8'h39, 8'h56);
    rdChk(8'h04, 8'h00);
    wr(8'h05, 8'h04);
    rdChk(8'h28, 8'h78);
    rdChk(8'h04, 8'h02);
  endtask : tBuffers

  task automatic tModes();
    // frequency mode, top 3: channel 0 toggles on the wrap after 4 ticks
    wr(8'h05, 8'h0C);
    wr(8'h28, 8'h03);
    wr(8'h01, 8'h11);
    wr(8'h00, 8'h01);
    repeat (3) @(posedge core_clk);
    wr(8'h00, 8'h00);
    #1 chk(8'(waveformOutputPin), 8'h01);
    chk(8'(waveformOverride), 8'h01);
    rdChk(8'h20, 8'h01);
    // two-ramp, top 4: stopped on the down slope, below compare 1
    wr(8'h05, 8'h0C);
    wr(8'h26, 8'h04);
    wr(8'h27, 8'h00);
    wr(8'h2A, 8'h02);
    wr(8'h01, 8'h25);
    wr(8'h00, 8'h01);
    repeat (5) @(posedge core_clk);
    wr(8'h00, 8'h00);
    #1 chk(8'(waveformOutputPin), 8'h02);
    rdChk(8'h04, 8'h01);
    rdChk(8'h20, 8'h01);
  endtask : tModes

  // ****************************************************************
  // clock, reset, sequence
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  initial begin
    repeat (60000) @(posedge core_clk);
    fails++;
    final_report();
  end

  initial begin
    rst = 1'b1;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrStrobe = 1'b0;
    regRdStrobe = 1'b0;
    fails = 0;
    compares = 0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    tReset();
    tCtrlE();
    tLevels();
    tPresc();
    tCmds();
    tBuffers();
    tModes();
    final_report();
  end
endmodule : tmr_normal_ctrl_tb

`default_nettype wire
